// ===== rtl/sca_pkg.sv
package sca_pkg;

   // Counter and register geometry.
   localparam int          CNT_W      = 32;
   localparam int          HALF_W     = 16;
   localparam int          ADDR_W     = 5;
   localparam int          DATA_W     = 32;

   // Register word offsets (byte addresses).
   localparam logic [4:0]  OFF_CNT_LO  = 5'h00;
   localparam logic [4:0]  OFF_CNT_HI  = 5'h04;
   localparam logic [4:0]  OFF_MATCH_LO = 5'h08;
   localparam logic [4:0]  OFF_MATCH_HI = 5'h0C;
   localparam logic [4:0]  OFF_STAT    = 5'h10;
   localparam logic [4:0]  OFF_LOAD_LO = 5'h14;
   localparam logic [4:0]  OFF_LOAD_HI = 5'h18;
   localparam logic [4:0]  OFF_CTRL    = 5'h1C;

   // Field positions.
   localparam int          CTRL_IE_BIT = 0;
   localparam int          STAT_IRQ_BIT = 0;

   // Reset values and the all-ones top count.
   localparam logic [31:0] CNT_RST     = 32'h0000_0000;
   localparam logic [31:0] ALL_ONES    = 32'hFFFF_FFFF;
   localparam logic [15:0] HALF_RST    = 16'h0000;
   localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
   localparam logic        IE_RST      = 1'b0;

   // APB request group as seen by the slave.
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } sca_apb_req_t;

endpackage

// ===== rtl/sca_seconds_alarm.sv
`timescale 1ns/1ps
`default_nettype none

module sca_seconds_alarm
   import sca_pkg::*;
(
   // Clock and reset.
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // APB slave request and answer.
   input  wire sca_apb_req_t      apb_req,
   output logic [DATA_W-1:0]      prdata,
   output logic                   pready,
   output logic                   pslverr,
   // One hertz tick pin, asynchronous to core_clk.
   input  wire logic              tick_1hz,
   // Alarm interrupt, active high.
   output logic                   alarm_interrupt
);

   // True when the address selects the given register word.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   logic              tick_s1_q;
   logic              tick_s2_q;
   logic              tick_s3_q;
   logic              tick_edge;
   logic [CNT_W-1:0]  cnt_q;
   logic [HALF_W-1:0] snap_q;
   logic [HALF_W-1:0] match_lo_q;
   logic [HALF_W-1:0] match_hi_q;
   logic [HALF_W-1:0] load_lo_q;
   logic [HALF_W-1:0] load_hi_q;
   logic              load_pend_q;
   logic              ctrl_ie_q;
   logic              stat_q;
   logic              stat_d;
   logic              match_eq;
   logic              match_prev_q;
   logic              match_rise;
   logic              setup;
   logic              access;
   logic              wr_acc;
   logic              mapped;
   logic [DATA_W-1:0] rd_data;

   // The tick pin passes two flip-flops; the third only feeds the edge finder.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         tick_s1_q <= tick_1hz;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   assign tick_edge = tick_s2_q & ~tick_s3_q;

   // APB phases: one wait-free access phase after each setup phase.
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable & pready;
   assign wr_acc = access & apb_req.pwrite;
   assign mapped = reg_hit(apb_req.paddr, OFF_CNT_LO) | reg_hit(apb_req.paddr, OFF_CNT_HI)
                 | reg_hit(apb_req.paddr, OFF_MATCH_LO) | reg_hit(apb_req.paddr, OFF_MATCH_HI)
                 | reg_hit(apb_req.paddr, OFF_STAT) | reg_hit(apb_req.paddr, OFF_LOAD_LO)
                 | reg_hit(apb_req.paddr, OFF_LOAD_HI) | reg_hit(apb_req.paddr, OFF_CTRL);

   // Seconds counter; a pending load replaces the increment on the tick.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_RST;
      end else if (tick_edge) begin
         if (load_pend_q) begin
            cnt_q <= {load_hi_q, load_lo_q};
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // A load_high write arms the load; the tick in the same cycle does not take it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pend_q <= 1'b0;
      end else if (wr_acc && reg_hit(apb_req.paddr, OFF_LOAD_HI)) begin
         load_pend_q <= 1'b1;
      end else if (tick_edge) begin
         load_pend_q <= 1'b0;
      end
   end

   // Writable halves and the control bit.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_lo_q <= HALF_RST;
         match_hi_q <= HALF_RST;
         load_lo_q  <= HALF_RST;
         load_hi_q  <= HALF_RST;
         ctrl_ie_q  <= IE_RST;
      end else if (wr_acc) begin
         if (reg_hit(apb_req.paddr, OFF_MATCH_LO)) begin
            match_lo_q <= apb_req.pwdata[HALF_W-1:0];
         end
         if (reg_hit(apb_req.paddr, OFF_MATCH_HI)) begin
            match_hi_q <= apb_req.pwdata[HALF_W-1:0];
         end
         if (reg_hit(apb_req.paddr, OFF_LOAD_LO)) begin
            load_lo_q <= apb_req.pwdata[HALF_W-1:0];
         end
         if (reg_hit(apb_req.paddr, OFF_LOAD_HI)) begin
            load_hi_q <= apb_req.pwdata[HALF_W-1:0];
         end
         if (reg_hit(apb_req.paddr, OFF_CTRL)) begin
            ctrl_ie_q <= apb_req.pwdata[CTRL_IE_BIT];
         end
      end
   end

   // The high half is caught at the same edge that samples the low half.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_q <= HALF_RST;
      end else if (setup && !apb_req.pwrite && reg_hit(apb_req.paddr, OFF_CNT_LO)) begin
         snap_q <= cnt_q[CNT_W-1:HALF_W];
      end
   end

   // Only the rising edge of equality is an event, so a clear during a
   // one-second match window is not undone by the still-equal count.
   assign match_eq   = (cnt_q == {match_hi_q, match_lo_q});
   assign match_rise = match_eq & ~match_prev_q;

   // Sticky status: a new event wins over a clear in the same cycle.
   always_comb begin
      stat_d = stat_q;
      if (wr_acc && reg_hit(apb_req.paddr, OFF_STAT)) begin
         stat_d = 1'b0;
      end
      if (match_rise) begin
         stat_d = 1'b1;
      end
   end

   // Event detector, sticky status and the registered interrupt output.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_prev_q    <= 1'b1; // Zeroed count and match are equal; not an event.
         stat_q          <= 1'b0;
         alarm_interrupt <= 1'b0;
      end else begin
         match_prev_q    <= match_eq;
         stat_q          <= stat_d;
         alarm_interrupt <= stat_q & ctrl_ie_q;
      end
   end

   // Read data mux; unused upper bits read as zero.
   always_comb begin
      rd_data = DATA_ZERO;
      unique case (1'b1)
         reg_hit(apb_req.paddr, OFF_CNT_LO):   rd_data[HALF_W-1:0] = cnt_q[HALF_W-1:0];
         reg_hit(apb_req.paddr, OFF_CNT_HI):   rd_data[HALF_W-1:0] = snap_q;
         reg_hit(apb_req.paddr, OFF_MATCH_LO): rd_data[HALF_W-1:0] = match_lo_q;
         reg_hit(apb_req.paddr, OFF_MATCH_HI): rd_data[HALF_W-1:0] = match_hi_q;
         reg_hit(apb_req.paddr, OFF_STAT):     rd_data[STAT_IRQ_BIT] = alarm_interrupt;
         reg_hit(apb_req.paddr, OFF_LOAD_LO):  rd_data[HALF_W-1:0] = load_lo_q;
         reg_hit(apb_req.paddr, OFF_LOAD_HI):  rd_data[HALF_W-1:0] = load_hi_q;
         reg_hit(apb_req.paddr, OFF_CTRL):     rd_data[CTRL_IE_BIT] = ctrl_ie_q;
         default:                              rd_data = DATA_ZERO;
      endcase
   end

   // Answer is registered in setup so the access phase sees it at once.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= DATA_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= apb_req.pwrite ? DATA_ZERO : rd_data;
         pready  <= 1'b1;
         pslverr <= ~mapped;
      end else begin
         prdata  <= DATA_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Checks of the counting, loading, alarm and bus behaviour.
   sequence s_load_cmd;
      wr_acc && reg_hit(apb_req.paddr, OFF_LOAD_HI);
   endsequence

   sequence s_tick_load;
      tick_edge && load_pend_q;
   endsequence

   a_tick_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
      tick_edge && !load_pend_q && cnt_q != ALL_ONES |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("counter did not advance on tick");

   a_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !tick_edge |=> $stable(cnt_q))
      else $error("counter changed without tick");

   a_load_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_load_cmd ##1 (!tick_edge)[*2] |=> load_pend_q && $stable(cnt_q))
      else $error("load applied before tick");

   a_load_apply: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_tick_load |=> cnt_q == $past({load_hi_q, load_lo_q})
          && (!load_pend_q || $past(wr_acc && reg_hit(apb_req.paddr, OFF_LOAD_HI))))
      else $error("start value not loaded on tick");

   a_wrap_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      tick_edge && !load_pend_q && cnt_q == ALL_ONES |=> cnt_q == CNT_RST)
      else $error("counter did not wrap to zero");

   a_snap_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      setup && !apb_req.pwrite && reg_hit(apb_req.paddr, OFF_CNT_LO)
      |=> snap_q == $past(cnt_q[CNT_W-1:HALF_W])
          && prdata[HALF_W-1:0] == $past(cnt_q[HALF_W-1:0]))
      else $error("low read or high snapshot wrong");

   a_snap_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      setup && !apb_req.pwrite && reg_hit(apb_req.paddr, OFF_CNT_HI)
      |=> prdata == {{(DATA_W-HALF_W){1'b0}}, $past(snap_q)})
      else $error("high read did not return snapshot");

   a_match_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_acc && reg_hit(apb_req.paddr, OFF_MATCH_HI)
      |=> match_hi_q == $past(apb_req.pwdata[HALF_W-1:0]))
      else $error("match high not written");

   a_match_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      setup && !apb_req.pwrite && reg_hit(apb_req.paddr, OFF_MATCH_LO)
      |=> prdata[HALF_W-1:0] == $past(match_lo_q))
      else $error("match low read back wrong");

   a_alarm_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      match_rise ##1 ctrl_ie_q |=> alarm_interrupt)
      else $error("alarm not raised on match");

   a_alarm_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_acc && reg_hit(apb_req.paddr, OFF_STAT) && !match_rise |=> !stat_q ##1 !alarm_interrupt)
      else $error("status write did not clear alarm");

   a_irq_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
      !ctrl_ie_q [*2] |-> !alarm_interrupt)
      else $error("masked alarm reached output");

   a_stat_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      setup && !apb_req.pwrite && reg_hit(apb_req.paddr, OFF_STAT)
      |=> prdata[STAT_IRQ_BIT] == $past(alarm_interrupt))
      else $error("status bit does not show alarm line");

   a_bad_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      setup && !mapped |=> pready && pslverr)
      else $error("unmapped access not flagged");

   a_bad_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_acc && !mapped |=> $stable({match_hi_q, match_lo_q, load_hi_q, load_lo_q, ctrl_ie_q}))
      else $error("unmapped write changed a register");

   a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      match_rise |=> stat_q)
      else $error("match event lost to a clear");

   a_mask_open: assert property (@(posedge core_clk) disable iff (!rst_n)
      stat_q && ctrl_ie_q |=> alarm_interrupt)
      else $error("unmasked status did not reach output");

endmodule

`default_nettype wire

// ===== dv/sca_apb_master.sv
`timescale 1ns/1ps
`default_nettype none

module sca_apb_master
   import sca_pkg::*;
(
   // Clock.
   input  wire logic              core_clk,
   // Request out, answer in.
   output var sca_apb_req_t       req,
   input  wire logic [DATA_W-1:0] prdata,
   input  wire logic              pready,
   input  wire logic              pslverr
);

   // The bus is idle from time zero.
   initial req = '0;

   // Setup, then access held until ready is seen or eight cycles pass; whole words only, no lanes.
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                       output logic err);
      int n;
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      rd  = prdata;
      // A slave that never answers shows up as an unknown error bit.
      err = (pready === 1'b1) ? pslverr : 1'bx;
      // Released lines carry the inverse, so a stale value never looks live.
      req <= '{1'b0, 1'b0, ~wr, ~a, ~d};
   endtask

endmodule
`default_nettype wire

// ===== dv/sca_seconds_alarm_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sca_seconds_alarm_tb
   import sca_pkg::*;
();

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] e;
      logic              err;
   } sca_row_t;

   // Ordinary accesses: the expected word only matters for reads.
   // Two reserved words are probed on purpose; other traffic stays mapped.
   localparam sca_row_t ROWS [13] = '{
      '{1'b1, OFF_MATCH_LO, 32'h0000_1234, 32'h0000_0000, 1'b0},
      '{1'b1, OFF_MATCH_HI, 32'hFFFF_ABCD, 32'h0000_0000, 1'b0},
      '{1'b0, OFF_MATCH_LO, 32'h0000_0000, 32'h0000_1234, 1'b0},
      '{1'b0, OFF_MATCH_HI, 32'h0000_0000, 32'h0000_ABCD, 1'b0},
      '{1'b1, OFF_CTRL,     32'h0000_0001, 32'h0000_0000, 1'b0},
      '{1'b0, OFF_CTRL,     32'h0000_0000, 32'h0000_0001, 1'b0},
      '{1'b0, OFF_STAT,     32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, 5'h02,        32'h0000_0000, 32'h0000_0000, 1'b1},
      '{1'b1, 5'h1E,        32'h0000_FFFF, 32'h0000_0000, 1'b1},
      '{1'b1, OFF_LOAD_LO,  32'h0000_FFFE, 32'h0000_0000, 1'b0},
      '{1'b1, OFF_LOAD_HI,  32'h0000_FFFF, 32'h0000_0000, 1'b0},
      '{1'b0, OFF_LOAD_LO,  32'h0000_0000, 32'h0000_FFFE, 1'b0},
      '{1'b0, OFF_LOAD_HI,  32'h0000_0000, 32'h0000_FFFF, 1'b0}};

   logic              core_clk;
   logic              rst_n;
   logic              tick_1hz;
   logic              pready;
   logic              pslverr;
   logic              alarm_interrupt;
   logic [DATA_W-1:0] prdata;
   logic [DATA_W-1:0] c0;
   logic              er0;
   sca_apb_req_t      apb_req;
   int                errors;
   int                checked;

   sca_seconds_alarm sca_seconds_alarm_inst (
      .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tick_1hz(tick_1hz),
      .alarm_interrupt(alarm_interrupt));

   sca_apb_master sca_apb_master_inst (
      .core_clk(core_clk), .req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Free-running 100 MHz clock.
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   task automatic give_verdict();
      if (errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] e,
                      input logic err_e);
      logic [DATA_W-1:0] rd;
      logic              er;
      sca_apb_master_inst.xfer(wr, a, d, rd, er);
      chk({31'h0, er}, {31'h0, err_e});
      if (!wr) chk(rd, e);
   endtask

   // Low half first, so the high half comes from the same instant.
   task automatic rd_cnt(input logic [DATA_W-1:0] exp);
      acc(1'b0, OFF_CNT_LO, 32'h0, {16'h0, exp[15:0]}, 1'b0);
      acc(1'b0, OFF_CNT_HI, 32'h0, {16'h0, exp[31:16]}, 1'b0);
   endtask

   // A tick held well over the two cycles that the pin filter needs.
   task automatic pulse();
      @(posedge core_clk);
      tick_1hz <= 1'b1;
      repeat (4) @(posedge core_clk);
      tick_1hz <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   // Lets registered outputs land before they are looked at.
   task automatic alarm_is(input logic v);
      repeat (3) @(posedge core_clk);
      #1;
      chk({31'h0, alarm_interrupt}, {31'h0, v});
   endtask

   // Guards against a hung handshake.
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   initial begin
      errors   = 0;
      checked  = 0;
      rst_n    = 1'b0;
      tick_1hz = 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk({31'h0, alarm_interrupt}, 32'h0);
      // Counter resets to zero; its content here is only noted, not checked.
      sca_apb_master_inst.xfer(1'b0, OFF_CNT_LO, 32'h0, c0, er0);
      foreach (ROWS[i]) acc(ROWS[i].wr, ROWS[i].a, ROWS[i].d, ROWS[i].e, ROWS[i].err);
      acc(1'b0, OFF_CNT_LO, 32'h0, c0, 1'b0);
      pulse();
      rd_cnt(32'hFFFF_FFFE);
      pulse();
      rd_cnt(32'hFFFF_FFFF);
      pulse();
      acc(1'b0, OFF_CNT_HI, 32'h0, 32'h0000_FFFF, 1'b0);
      rd_cnt(32'h0000_0000);
      acc(1'b1, OFF_MATCH_LO, 32'h0000_0001, 32'h0, 1'b0);
      acc(1'b1, OFF_MATCH_HI, 32'h0000_0000, 32'h0, 1'b0);
      pulse();
      rd_cnt(32'h0000_0001);
      alarm_is(1'b1);
      acc(1'b0, OFF_STAT, 32'h0, 32'h0000_0001, 1'b0);
      acc(1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
      alarm_is(1'b0);
      acc(1'b0, OFF_STAT, 32'h0, 32'h0000_0000, 1'b0);
      acc(1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
      alarm_is(1'b1);
      acc(1'b1, OFF_STAT, 32'hDEAD_BEEF, 32'h0, 1'b0);
      alarm_is(1'b0);
      acc(1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
      pulse();
      rd_cnt(32'h0000_0002);
      acc(1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
      alarm_is(1'b0);
      // A mid-run reset zeroes count and match alike; that is not a match event.
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
      alarm_is(1'b0);
      acc(1'b0, OFF_STAT, 32'h0, 32'h0000_0000, 1'b0);
      give_verdict();
   end

endmodule
`default_nettype wire
